// File: design/tf_param_defines.svh
`ifndef TF_PARAM_DEFINES_SVH
`define TF_PARAM_DEFINES_SVH

// Register width on the low data lines
`define TF_REG_W 8

// Task-file address codes on DA2..DA0, with CS0 asserted and CS1 negated
`define TF_DA_ERR_FEAT 3'h1
`define TF_DA_COUNT 3'h2
`define TF_DA_NUMBER 3'h3
`define TF_DA_DSH 3'h6
`define TF_DA_CMD 3'h7

// Field positions
`define TF_DEV_BIT 4
`define TF_ABORT_BIT 2
`define TF_OBS_HI_BIT 7
`define TF_OBS_LO_BIT 5

// Drive-select bits that are stored (obsolete bits 7 and 5 dropped)
`define TF_DSH_KEEP_MASK 8'h5F
// Drive-select bits that become command parameters (select bit dropped too)
`define TF_DSH_PARAM_MASK 8'h4F

// Reset values
`define TF_DSH_RESET 8'h00
`define TF_ERR_RESET 8'h01
`define TF_FEAT_RESET 8'h00
`define TF_COUNT_RESET 8'h01
`define TF_NUMBER_RESET 8'h01
`define TF_CMD_RESET 8'h00
`define TF_INVALID_READ 8'h00

// Synchroniser vector: cs0_n, cs1_n, da, dior_n, diow_n, dmack_n, dev_position, data
`define TF_PIN_W 17
`define TF_PIN_IDLE 17'h18E00

`endif

// File: design/tf_param_pkg.sv
package tf_param_pkg;

  // Which register a task-file address decodes to
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_ERR_FEAT,
    SEL_COUNT,
    SEL_NUMBER,
    SEL_DSH,
    SEL_CMD
  } reg_sel_type;

endpackage

// File: design/param_latch_if.sv
`timescale 1ns/1ns
`default_nettype none

interface param_latch_if;
  // Live register contents and command strobe
  logic take;
  logic [7:0] code;
  logic [7:0] feature;
  logic [7:0] count;
  logic [7:0] number;
  logic [7:0] dsh;
  // Parameters frozen at the command write
  logic lat_valid;
  logic [7:0] lat_code;
  logic [7:0] lat_feature;
  logic [7:0] lat_count;
  logic [7:0] lat_number;
  logic [7:0] lat_dsh;

  modport source (
    output take, code, feature, count, number, dsh,
    input lat_valid, lat_code, lat_feature, lat_count, lat_number, lat_dsh
  );
  modport latch (
    input take, code, feature, count, number, dsh,
    output lat_valid, lat_code, lat_feature, lat_count, lat_number, lat_dsh
  );
endinterface

`default_nettype wire

// File: design/param_latch.sv
`timescale 1ns/1ns
`default_nettype none
`include "tf_param_defines.svh"

module param_latch (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register side
  param_latch_if.latch pl
);

  logic valid_ff, nxt_valid;
  logic [7:0] code_ff, nxt_code;
  logic [7:0] feat_ff, nxt_feat;
  logic [7:0] count_ff, nxt_count;
  logic [7:0] number_ff, nxt_number;
  logic [7:0] dsh_ff, nxt_dsh;

  // Freeze all parameters on an accepted command write
  always_comb begin
    nxt_valid = pl.take;
    nxt_code = code_ff;
    nxt_feat = feat_ff;
    nxt_count = count_ff;
    nxt_number = number_ff;
    nxt_dsh = dsh_ff;
    if (pl.take) begin
      nxt_code = pl.code;
      nxt_feat = pl.feature;
      nxt_count = pl.count;
      nxt_number = pl.number;
      nxt_dsh = pl.dsh & `TF_DSH_PARAM_MASK;
    end
  end

  // Parameter registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      valid_ff <= 1'b0;
      code_ff <= `TF_CMD_RESET;
      feat_ff <= `TF_FEAT_RESET;
      count_ff <= `TF_COUNT_RESET;
      number_ff <= `TF_NUMBER_RESET;
      dsh_ff <= `TF_DSH_RESET;
    end else begin
      valid_ff <= nxt_valid;
      code_ff <= nxt_code;
      feat_ff <= nxt_feat;
      count_ff <= nxt_count;
      number_ff <= nxt_number;
      dsh_ff <= nxt_dsh;
    end
  end

  assign pl.lat_valid = valid_ff;
  assign pl.lat_code = code_ff;
  assign pl.lat_feature = feat_ff;
  assign pl.lat_count = count_ff;
  assign pl.lat_number = number_ff;
  assign pl.lat_dsh = dsh_ff;

endmodule // param_latch

`default_nettype wire

// File: design/task_file_param_registers.sv
`timescale 1ns/1ns
`default_nettype none
`include "tf_param_defines.svh"

module task_file_param_registers #(
  parameter logic [7:0] DEVICE_RESET_CODE = 8'h00,
  parameter bit SUPPORTS_DEVICE_RESET = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Host task-file pins
  input wire logic cs0_n,
  input wire logic cs1_n,
  input wire logic [2:0] da,
  input wire logic dior_n,
  input wire logic diow_n,
  input wire logic dmack_n,
  input wire logic [7:0] dd_in,
  output logic [7:0] dd_out,
  output logic dd_oe,
  // Unit position strap
  input wire logic dev_position,
  // Device core status
  input wire logic bsy,
  input wire logic drq,
  input wire logic err_flag,
  input wire logic sleep_mode,
  input wire logic srst,
  // Device core updates
  input wire logic diag_load,
  input wire logic [7:0] diag_code,
  input wire logic error_load,
  input wire logic [7:0] error_code,
  input wire logic abort_set,
  input wire logic signature_load,
  input wire logic [7:0] sig_dsh,
  input wire logic [7:0] sig_count,
  input wire logic [7:0] sig_number,
  // Command parameters to the core
  output logic cmd_strobe,
  output logic [7:0] cmd_code,
  output logic [7:0] param_feature,
  output logic [7:0] param_count,
  output logic [7:0] param_number,
  output logic [7:0] param_dsh,
  // Selection state
  output logic drive_select_bit,
  output logic dev_selected
);

  // Decode of the chip selects and DA lines
  function automatic tf_param_pkg::reg_sel_type decode(
    input logic c0_n,
    input logic c1_n,
    input logic [2:0] a
  );
    tf_param_pkg::reg_sel_type s;
    s = tf_param_pkg::SEL_NONE;
    if (!c0_n && c1_n) begin
      unique case (a)
        `TF_DA_ERR_FEAT: s = tf_param_pkg::SEL_ERR_FEAT;
        `TF_DA_COUNT: s = tf_param_pkg::SEL_COUNT;
        `TF_DA_NUMBER: s = tf_param_pkg::SEL_NUMBER;
        `TF_DA_DSH: s = tf_param_pkg::SEL_DSH;
        `TF_DA_CMD: s = tf_param_pkg::SEL_CMD;
        default: s = tf_param_pkg::SEL_NONE;
      endcase
    end
    return s;
  endfunction

  logic [`TF_PIN_W-1:0] sync1_ff, sync2_ff;
  logic s_cs0_n, s_cs1_n, s_dior_n, s_diow_n, s_dmack_n, s_pos;
  logic [2:0] s_da;
  logic [7:0] s_dd;

  // Two-stage synchroniser on every pin
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_ff <= `TF_PIN_IDLE;
      sync2_ff <= `TF_PIN_IDLE;
    end else begin
      sync1_ff <= {cs0_n, cs1_n, da, dior_n, diow_n, dmack_n, dev_position, dd_in};
      sync2_ff <= sync1_ff;
    end
  end

  assign s_cs0_n = sync2_ff[16];
  assign s_cs1_n = sync2_ff[15];
  assign s_da = sync2_ff[14:12];
  assign s_dior_n = sync2_ff[11];
  assign s_diow_n = sync2_ff[10];
  assign s_dmack_n = sync2_ff[9];
  assign s_pos = sync2_ff[8];
  assign s_dd = sync2_ff[7:0];

  // Write capture: address and data follow the pins while the strobe is low, held once it rises
  logic diow_d_ff, nxt_diow_d;
  logic wcs0_ff, nxt_wcs0;
  logic wcs1_ff, nxt_wcs1;
  logic wdmack_ff, nxt_wdmack;
  logic [2:0] wda_ff, nxt_wda;
  logic [7:0] wdd_ff, nxt_wdd;
  logic wr_event;

  always_comb begin
    nxt_diow_d = s_diow_n;
    nxt_wcs0 = wcs0_ff;
    nxt_wcs1 = wcs1_ff;
    nxt_wdmack = wdmack_ff;
    nxt_wda = wda_ff;
    nxt_wdd = wdd_ff;
    if (!s_diow_n) begin
      nxt_wcs0 = s_cs0_n;
      nxt_wcs1 = s_cs1_n;
      nxt_wdmack = s_dmack_n;
      nxt_wda = s_da;
      nxt_wdd = s_dd;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      diow_d_ff <= 1'b1;
      wcs0_ff <= 1'b1;
      wcs1_ff <= 1'b1;
      wdmack_ff <= 1'b1;
      wda_ff <= 3'h0;
      wdd_ff <= 8'h00;
    end else begin
      diow_d_ff <= nxt_diow_d;
      wcs0_ff <= nxt_wcs0;
      wcs1_ff <= nxt_wcs1;
      wdmack_ff <= nxt_wdmack;
      wda_ff <= nxt_wda;
      wdd_ff <= nxt_wdd;
    end
  end

  // Write completes on the rising edge of the strobe
  assign wr_event = s_diow_n && !diow_d_ff;

  // Register file state
  logic [7:0] dsh_ff, nxt_dsh;
  logic [7:0] err_ff, nxt_err;
  logic [7:0] feat_ff, nxt_feat;
  logic [7:0] count_ff, nxt_count;
  logic [7:0] number_ff, nxt_number;
  logic [7:0] code_ff, nxt_code;
  logic take_ff, nxt_take;
  logic sel_ff, nxt_sel;
  logic selected, host_idle, err_hold;
  tf_param_pkg::reg_sel_type wsel;

  assign selected = (s_pos == dsh_ff[`TF_DEV_BIT]);
  assign host_idle = !bsy && !drq && wdmack_ff;
  assign err_hold = err_flag && !bsy && !drq;
  assign wsel = decode(wcs0_ff, wcs1_ff, wda_ff);

  // Host writes, core updates and soft reset, lowest priority first
  always_comb begin
    nxt_dsh = dsh_ff;
    nxt_err = err_ff;
    nxt_feat = feat_ff;
    nxt_count = count_ff;
    nxt_number = number_ff;
    nxt_code = code_ff;
    nxt_take = 1'b0;
    nxt_sel = selected;
    if (wr_event) begin
      unique case (wsel)
        tf_param_pkg::SEL_DSH: begin
          if (host_idle) begin
            nxt_dsh = wdd_ff & `TF_DSH_KEEP_MASK;
          end
        end
        tf_param_pkg::SEL_ERR_FEAT: begin
          if (host_idle && selected) begin
            nxt_feat = wdd_ff;
          end
        end
        tf_param_pkg::SEL_COUNT: begin
          if (host_idle && selected) begin
            nxt_count = wdd_ff;
          end
        end
        tf_param_pkg::SEL_NUMBER: begin
          if (host_idle && selected) begin
            nxt_number = wdd_ff;
          end
        end
        tf_param_pkg::SEL_CMD: begin
          if (selected && wdmack_ff && ((!bsy && !drq) || wdd_ff == DEVICE_RESET_CODE)) begin
            nxt_code = wdd_ff;
            nxt_take = 1'b1;
          end
        end
        tf_param_pkg::SEL_NONE: begin
        end
      endcase
    end
    if (!err_hold) begin
      if (signature_load) begin
        nxt_dsh = sig_dsh & `TF_DSH_KEEP_MASK;
        nxt_count = sig_count;
        nxt_number = sig_number;
      end
      if (diag_load) begin
        nxt_err = diag_code;
      end else if (error_load) begin
        nxt_err = error_code;
      end
      if (abort_set) begin
        nxt_err[`TF_ABORT_BIT] = 1'b1;
      end
    end
    if (srst) begin
      nxt_dsh = `TF_DSH_RESET;
      nxt_err = `TF_ERR_RESET;
      nxt_feat = `TF_FEAT_RESET;
      nxt_count = `TF_COUNT_RESET;
      nxt_number = `TF_NUMBER_RESET;
      nxt_take = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dsh_ff <= `TF_DSH_RESET;
      err_ff <= `TF_ERR_RESET;
      feat_ff <= `TF_FEAT_RESET;
      count_ff <= `TF_COUNT_RESET;
      number_ff <= `TF_NUMBER_RESET;
      code_ff <= `TF_CMD_RESET;
      take_ff <= 1'b0;
      sel_ff <= 1'b0;
    end else begin
      dsh_ff <= nxt_dsh;
      err_ff <= nxt_err;
      feat_ff <= nxt_feat;
      count_ff <= nxt_count;
      number_ff <= nxt_number;
      code_ff <= nxt_code;
      take_ff <= nxt_take;
      sel_ff <= nxt_sel;
    end
  end

  // Read path: data and enable registered from the live strobe
  logic [7:0] rd_data_ff, nxt_rd_data;
  logic rd_oe_ff, nxt_rd_oe;
  tf_param_pkg::reg_sel_type rsel;

  assign rsel = decode(s_cs0_n, s_cs1_n, s_da);

  always_comb begin
    nxt_rd_oe = 1'b0;
    nxt_rd_data = `TF_INVALID_READ;
    if (!s_dior_n && s_dmack_n && selected) begin
      unique case (rsel)
        tf_param_pkg::SEL_DSH: begin
          nxt_rd_oe = 1'b1;
          if (!bsy && (!sleep_mode || SUPPORTS_DEVICE_RESET)) begin
            nxt_rd_data = dsh_ff;
          end
        end
        tf_param_pkg::SEL_ERR_FEAT: begin
          nxt_rd_oe = 1'b1;
          if (!sleep_mode) begin
            nxt_rd_data = err_ff;
          end
        end
        tf_param_pkg::SEL_COUNT: begin
          nxt_rd_oe = 1'b1;
          if (!bsy && !drq && !sleep_mode) begin
            nxt_rd_data = count_ff;
          end
        end
        tf_param_pkg::SEL_NUMBER: begin
          nxt_rd_oe = 1'b1;
          if (!bsy && !drq && !sleep_mode) begin
            nxt_rd_data = number_ff;
          end
        end
        tf_param_pkg::SEL_CMD, tf_param_pkg::SEL_NONE: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_ff <= `TF_INVALID_READ;
      rd_oe_ff <= 1'b0;
    end else begin
      rd_data_ff <= nxt_rd_data;
      rd_oe_ff <= nxt_rd_oe;
    end
  end

  // Command parameter capture
  param_latch_if pl ();

  assign pl.take = take_ff;
  assign pl.code = code_ff;
  assign pl.feature = feat_ff;
  assign pl.count = count_ff;
  assign pl.number = number_ff;
  assign pl.dsh = dsh_ff;

  param_latch u_latch (
    .clk(clk),
    .arst_n(arst_n),
    .pl(pl)
  );

  // Outputs
  assign dd_out = rd_data_ff;
  assign dd_oe = rd_oe_ff;
  assign cmd_strobe = pl.lat_valid;
  assign cmd_code = pl.lat_code;
  assign param_feature = pl.lat_feature;
  assign param_count = pl.lat_count;
  assign param_number = pl.lat_number;
  assign param_dsh = pl.lat_dsh;
  assign drive_select_bit = dsh_ff[`TF_DEV_BIT];
  assign dev_selected = sel_ff;

endmodule // task_file_param_registers

`default_nettype wire

// File: tb/tfpr_checker_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module tfpr_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Host strobes and read drive
  input wire logic dior_n,
  input wire logic diow_n,
  input wire logic dd_oe,
  // Position strap and core inputs
  input wire logic dev_position,
  input wire logic bsy,
  input wire logic srst,
  input wire logic signature_load,
  // Command and selection
  input wire logic cmd_strobe,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] param_feature,
  input wire logic [7:0] param_count,
  input wire logic [7:0] param_number,
  input wire logic [7:0] param_dsh,
  input wire logic drive_select_bit,
  input wire logic dev_selected
);
  logic [3:0] wr_age_ff, nxt_wr_age, rd_age_ff, nxt_rd_age;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Cycles since each strobe pin was last low, saturating
  always_comb begin
    nxt_wr_age = diow_n ? wr_age_ff + {3'h0, wr_age_ff != 4'hF} : 4'h0;
    nxt_rd_age = dior_n ? rd_age_ff + {3'h0, rd_age_ff != 4'hF} : 4'h0;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_age_ff <= 4'hF;
      rd_age_ff <= 4'hF;
    end else begin
      wr_age_ff <= nxt_wr_age;
      rd_age_ff <= nxt_rd_age;
    end
  end
  a_strobe_one_cycle: assert property (cmd_strobe |=> !cmd_strobe)
    else $error("command strobe too long");
  a_params_frozen: assert property (
    $changed({cmd_code, param_feature, param_count, param_number, param_dsh}) && !$past(srst)
    |-> ##[0:1] cmd_strobe) else $error("parameters changed without command");
  a_dsh_param_mask: assert property ((param_dsh & 8'hB0) == 8'h00)
    else $error("select or obsolete bit in parameter");
  a_select_match: assert property (
    (dev_position == drive_select_bit && $stable(dev_position) && $stable(drive_select_bit)) [*4]
    |-> dev_selected) else $error("unit not selected");
  a_select_miss: assert property (
    (dev_position != drive_select_bit && $stable(dev_position) && $stable(drive_select_bit)) [*4]
    |-> !dev_selected) else $error("wrong unit selected");
  a_busy_keeps_sel: assert property (
    (bsy && !srst && !signature_load) [*8] |-> $stable(drive_select_bit))
    else $error("select changed while busy");
  a_srst_reload: assert property (srst |=> !drive_select_bit ##1 !cmd_strobe)
    else $error("soft reset values wrong");
  a_cmd_after_write: assert property (cmd_strobe |-> wr_age_ff inside {[4'h2:4'h8]})
    else $error("command without write");
  a_read_window: assert property (dd_oe |-> rd_age_ff <= 4'h5 && dev_selected)
    else $error("drive outside read");
endmodule // tfpr_checker
bind task_file_param_registers tfpr_checker chk (.clk(clk), .arst_n(arst_n), .dior_n(dior_n),
  .diow_n(diow_n), .dd_oe(dd_oe), .dev_position(dev_position), .bsy(bsy), .srst(srst),
  .signature_load(signature_load), .cmd_strobe(cmd_strobe), .cmd_code(cmd_code),
  .param_feature(param_feature), .param_count(param_count), .param_number(param_number),
  .param_dsh(param_dsh), .drive_select_bit(drive_select_bit), .dev_selected(dev_selected));
`default_nettype wire

// File: tb/host_adapter_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_adapter_model (
  // Clock
  input wire logic clk,
  // Task-file pins
  output logic cs0_n,
  output logic cs1_n,
  output logic [2:0] da,
  output logic dior_n,
  output logic diow_n,
  output logic dmack_n,
  output logic [7:0] dd_in,
  input wire logic [7:0] dd_out,
  input wire logic dd_oe
);
  // Idle bus
  initial begin
    {cs0_n, cs1_n, dior_n, diow_n, dmack_n} = 5'h1F;
    da = 3'h0;
    dd_in = 8'h00;
  end
  // DMA acknowledge level
  task automatic ack(input logic v);
    @(negedge clk);
    dmack_n = v;
  endtask
  // Strobe held past sync; data released inverted
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    {cs0_n, da, dd_in, diow_n} = {1'b0, a, d, 1'b0};
    repeat (4) @(negedge clk);
    diow_n = 1'b1;
    repeat (2) @(negedge clk);
    {cs0_n, dd_in} = {1'b1, ~d};
    repeat (4) @(negedge clk);
  endtask
  // Read sampled once the drive has settled
  task automatic rd(input logic [2:0] a, output logic [7:0] d, output logic oe);
    @(negedge clk);
    {cs0_n, da, dior_n} = {1'b0, a, 1'b0};
    repeat (5) @(negedge clk);
    {d, oe} = {dd_out, dd_oe};
    {cs0_n, dior_n} = 2'h3;
    repeat (4) @(negedge clk);
  endtask
endmodule // host_adapter_model
`default_nettype wire

// File: tb/task_file_param_registers_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module task_file_param_registers_tb_top;
  localparam logic [7:0] RST_CODE = 8'h08;
  logic clk = 1'b0, arst_n = 1'b0, dev_position = 1'b0, bsy = 1'b0, drq = 1'b0;
  logic err_flag = 1'b0, sleep_mode = 1'b0, srst = 1'b0, diag_load = 1'b0;
  logic error_load = 1'b0, abort_set = 1'b0, signature_load = 1'b0;
  logic [7:0] diag_code = 8'h00, error_code = 8'h00, sig_dsh = 8'h00, sig_count = 8'h00;
  logic [7:0] sig_number = 8'h00, dd_in, dd_out, cmd_code, param_feature, param_count;
  logic [7:0] param_number, param_dsh, rv;
  logic [2:0] da;
  logic cs0_n, cs1_n, dior_n, diow_n, dmack_n, dd_oe, cmd_strobe, drive_select_bit;
  logic dev_selected, oe;
  int fail_count = 0;
  int n_checks = 0;
  always #50 clk = ~clk;
  host_adapter_model host (.clk(clk), .cs0_n(cs0_n), .cs1_n(cs1_n), .da(da), .dior_n(dior_n),
    .diow_n(diow_n), .dmack_n(dmack_n), .dd_in(dd_in), .dd_out(dd_out), .dd_oe(dd_oe));
  task_file_param_registers #(.DEVICE_RESET_CODE(RST_CODE)) uut (.clk(clk), .arst_n(arst_n),
    .cs0_n(cs0_n), .cs1_n(cs1_n), .da(da), .dior_n(dior_n), .diow_n(diow_n), .dmack_n(dmack_n),
    .dd_in(dd_in), .dd_out(dd_out), .dd_oe(dd_oe), .dev_position(dev_position), .bsy(bsy),
    .drq(drq), .err_flag(err_flag), .sleep_mode(sleep_mode), .srst(srst),
    .diag_load(diag_load), .diag_code(diag_code), .error_load(error_load),
    .error_code(error_code), .abort_set(abort_set), .signature_load(signature_load),
    .sig_dsh(sig_dsh), .sig_count(sig_count), .sig_number(sig_number),
    .cmd_strobe(cmd_strobe), .cmd_code(cmd_code), .param_feature(param_feature),
    .param_count(param_count), .param_number(param_number), .param_dsh(param_dsh),
    .drive_select_bit(drive_select_bit), .dev_selected(dev_selected));
  // Compare and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Read with expected drive and data
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp, input logic exp_oe);
    host.rd(a, rv, oe);
    check("read enable", {7'h00, oe}, {7'h00, exp_oe});
    if (exp_oe) check("read data", rv, exp);
  endtask
  // Command write watched for its strobe
  task automatic issue(input logic [7:0] code, input logic exp);
    logic seen;
    seen = 1'b0;
    fork
      host.wr(3'h7, code);
      repeat (16) @(negedge clk) seen |= cmd_strobe;
    join
    check("command strobe", {7'h00, seen}, {7'h00, exp});
  endtask
  // One-cycle core load pulses: diag, error, abort, signature
  task automatic core_pulse(input logic [3:0] m);
    @(negedge clk) {diag_load, error_load, abort_set, signature_load} = m;
    @(negedge clk) {diag_load, error_load, abort_set, signature_load} = 4'h0;
  endtask
  task automatic note(input int n);
    $display("test %0d done", n);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog
  initial begin
    #500000;
    fail_count++;
    final_report();
  end
  // Test sequence
  initial begin
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    rd_chk(3'h1, 8'h01, 1'b1);
    rd_chk(3'h2, 8'h01, 1'b1);
    rd_chk(3'h6, 8'h00, 1'b1);
    rd_chk(3'h7, 8'h00, 1'b0);
    note(1);
    // Writes, shared address, obsolete bits, command capture
    host.wr(3'h2, 8'hA5);
    host.wr(3'h3, 8'h3C);
    host.wr(3'h1, 8'h5A);
    host.wr(3'h6, 8'hEF);
    rd_chk(3'h3, 8'h3C, 1'b1);
    rd_chk(3'h1, 8'h01, 1'b1);
    rd_chk(3'h6, 8'h4F, 1'b1);
    issue(8'hC8, 1'b1);
    check("code", cmd_code, 8'hC8);
    check("feature", param_feature, 8'h5A);
    check("count", param_count, 8'hA5);
    check("number", param_number, 8'h3C);
    check("dsh", param_dsh, 8'h4F);
    note(2);
    // Other unit addressed, then strap moved; DMA ack blocks access
    host.wr(3'h6, 8'h10);
    check("select", {7'h00, drive_select_bit}, 8'h01);
    check("selected", {7'h00, dev_selected}, 8'h00);
    rd_chk(3'h2, 8'h00, 1'b0);
    host.wr(3'h2, 8'h99);
    dev_position = 1'b1;
    rd_chk(3'h6, 8'h10, 1'b1);
    check("selected", {7'h00, dev_selected}, 8'h01);
    host.ack(1'b0);
    host.wr(3'h2, 8'h66);
    rd_chk(3'h2, 8'h00, 1'b0);
    host.ack(1'b1);
    note(3);
    // Busy and data request
    bsy = 1'b1;
    host.wr(3'h2, 8'h77);
    host.wr(3'h6, 8'h00);
    rd_chk(3'h2, 8'h00, 1'b1);
    rd_chk(3'h6, 8'h00, 1'b1);
    issue(8'h11, 1'b0);
    issue(RST_CODE, 1'b1);
    {bsy, drq} = 2'h1;
    host.wr(3'h3, 8'h44);
    drq = 1'b0;
    rd_chk(3'h2, 8'hA5, 1'b1);
    rd_chk(3'h3, 8'h3C, 1'b1);
    check("select held", {7'h00, drive_select_bit}, 8'h01);
    note(4);
    // Error contents, hold, sleep
    error_code = 8'h10;
    core_pulse(4'h6);
    rd_chk(3'h1, 8'h14, 1'b1);
    err_flag = 1'b1;
    error_code = 8'h40;
    core_pulse(4'h4);
    rd_chk(3'h1, 8'h14, 1'b1);
    sleep_mode = 1'b1;
    rd_chk(3'h1, 8'h00, 1'b1);
    rd_chk(3'h6, 8'h10, 1'b1);
    {sleep_mode, err_flag} = 2'h0;
    note(5);
    // Signature with diagnostic code, then soft reset
    {sig_count, diag_code} = {8'h5C, 8'h81};
    core_pulse(4'h9);
    check("sig select", {7'h00, drive_select_bit}, 8'h00);
    dev_position = 1'b0;
    rd_chk(3'h1, 8'h81, 1'b1);
    rd_chk(3'h2, 8'h5C, 1'b1);
    srst = 1'b1;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    rd_chk(3'h2, 8'h01, 1'b1);
    rd_chk(3'h1, 8'h01, 1'b1);
    note(6);
    final_report();
  end
endmodule // task_file_param_registers_tb_top
`default_nettype wire
